/* design/cks_defines.vh */
// Constants of the base clock select and PLL control block.
`ifndef CKS_DEFINES_VH
`define CKS_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CKS_ADDR_PLL_CONTROL    8'h1c
`define CKS_ADDR_PLL_PROGRAM    8'h20
`define CKS_ADDR_BANDWIDTH      8'h24

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CKS_CTL_IRQ_EN_BIT      7
`define CKS_CTL_FLAG_BIT        6
`define CKS_CTL_PLL_ON_BIT      5
`define CKS_CTL_SELECT_BIT      4
`define CKS_CTL_UNUSED_ONES     4'hf
`define CKS_BW_AUTO_BIT         7
`define CKS_BW_LOCK_BIT         6
`define CKS_BW_ACQ_BIT          5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CKS_MULT_RESET          4'h6
`define CKS_RANGE_RESET         4'h6

// ----------------------------------------------------------------------
// Timing counts: switch-over in source edges, timeout in clk cycles
// ----------------------------------------------------------------------
`define CKS_SWITCH_EDGES        2'h3
`define CKS_SWITCH_TIMEOUT      8'h40

`endif

/* design/cks_edge_count.v */
// Rising edge detector and switch-over edge counter for one source clock.
`default_nettype none
`include "cks_defines.vh"

module cks_edge_count (
  // Clock and control
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       arm,
  // Source clock, sampled as a synchronous level
  input  wire       src_in,
  // Results
  output reg        rise_q,
  output reg        done_q
);

  reg       src_q;
  reg [1:0] cnt_q;

  // Count rising edges of the source after arm, saturating at the limit.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_q  <= 1'b0;
      rise_q <= 1'b0;
      cnt_q  <= 2'h0;
      done_q <= 1'b0;
    end else if (ce) begin
      src_q  <= src_in;
      rise_q <= src_in & ~src_q;
      if (arm) begin
        cnt_q  <= 2'h0;
        done_q <= 1'b0;
      end else if (src_in & ~src_q & ~done_q) begin
        cnt_q  <= cnt_q + 2'h1;
        done_q <= (cnt_q + 2'h1) == `CKS_SWITCH_EDGES;
      end
    end
  end

endmodule
`default_nettype wire

/* design/cks_ctrl_top.v */
// Base clock selector, divider and PLL control registers on Avalon-MM.
//
// Decided for this implementation: the Avalon-MM register port.
`default_nettype none
`include "cks_defines.vh"

// Functional notes
// - Multiplier zero behaves as multiplier one.
// - Range zero: PLL off, crystal forced.
// - Switch waits three edges each, output static.
// - Divide selected clock by two, 50 percent.
// - Select one picks VCO, zero picks crystal.
// - Select held zero when PLL off/range zero.
// - PLL on forced while select is set.
// - Lock irq enable zero when auto off.
// - Flag sets on lock toggle; irq when enabled.
// - Flag and lock read zero when auto off.
// - Reading control register clears flag.
// - Reset: PLL on, enable and flag cleared.
// - Reset and stop clear base select.
// - Program register read-only while PLL on.
// - Low four control bits read as ones.
// - Interrupt output comes from lock detection.
// - Lock bit read-only, set when VCO locked.
// - Oscillator disabled holds clock, irq outputs low.
module cks_ctrl_top (
  // Clock, reset, clock enable
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // Avalon-MM slave
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // Source clocks and analog status, synchronous levels
  input  wire        crystal_clock,
  input  wire        vco_clock,
  input  wire        lock_in,
  input  wire        acq_in,
  // System integration unit
  input  wire        osc_enable_in,
  input  wire        stop_in,
  output reg         crystal_clock_out,
  output reg         base_clock_out,
  output reg         clock_irq_out,
  // Analog PLL controls
  output reg         pll_enable_out,
  output reg  [3:0]  feedback_mult_out,
  output reg  [3:0]  range_mult_out,
  output reg         tracking_mode_out
);

  // --------------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  reg       lock_irq_enable_q;
  reg       lock_change_flag_q;
  reg       pll_on_a_q;
  reg       base_select_q;
  reg [3:0] mult_q;
  reg [3:0] range_select_field_q;
  reg       auto_q;
  reg       acq_q;
  reg       lock_q;

  wire       bus_req   = read | write;
  wire       bus_take  = bus_req & ~waitrequest;
  wire       wr_take   = bus_take & write & byteenable[0];
  wire       rd_take   = bus_take & read;
  wire [7:0] wd        = writedata[7:0];
  wire       wr_ctl    = wr_take & (address == `CKS_ADDR_PLL_CONTROL);
  wire       wr_prog   = wr_take & (address == `CKS_ADDR_PLL_PROGRAM);
  wire       wr_bw     = wr_take & (address == `CKS_ADDR_BANDWIDTH);
  wire       rd_ctl    = rd_take & (address == `CKS_ADDR_PLL_CONTROL);
  wire       range_off = (range_select_field_q == 4'h0);
  wire       lock_tgl  = lock_in ^ lock_q;

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  reg base_select_d;
  reg pll_on_a_d;
  reg lock_irq_enable_d;
  reg lock_change_flag_d;

  always @* begin
    base_select_d      = base_select_q;
    pll_on_a_d         = pll_on_a_q;
    lock_irq_enable_d  = lock_irq_enable_q;
    lock_change_flag_d = lock_change_flag_q;
    // Decisions use the current bit values, so PLL on and select cannot
    // both change in one write.
    if (wr_ctl) begin
      if (base_select_q == 1'b0) begin
        pll_on_a_d = wd[`CKS_CTL_PLL_ON_BIT];
      end
      if (pll_on_a_q && !range_off) begin
        base_select_d = wd[`CKS_CTL_SELECT_BIT];
      end
      if (auto_q) begin
        lock_irq_enable_d = wd[`CKS_CTL_IRQ_EN_BIT];
      end
    end
    if (!auto_q) begin
      lock_irq_enable_d = 1'b0;
    end
    if (!pll_on_a_q || range_off || stop_in) begin
      base_select_d = 1'b0;
    end
    // A write that selects the loop while it runs must not also stop it.
    if (base_select_d) begin
      pll_on_a_d = 1'b1;
    end
    if (rd_ctl) begin
      lock_change_flag_d = 1'b0;
    end
    if (auto_q && lock_tgl) begin
      lock_change_flag_d = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pll_on_a_q         <= 1'b1;
      lock_irq_enable_q  <= 1'b0;
      lock_change_flag_q <= 1'b0;
      base_select_q      <= 1'b0;
      mult_q             <= `CKS_MULT_RESET;
      range_select_field_q <= `CKS_RANGE_RESET;
      auto_q             <= 1'b0;
      acq_q              <= 1'b0;
      lock_q             <= 1'b0;
    end else if (ce) begin
      pll_on_a_q         <= pll_on_a_d;
      lock_irq_enable_q  <= lock_irq_enable_d;
      lock_change_flag_q <= lock_change_flag_d;
      base_select_q      <= base_select_d;
      lock_q             <= lock_in;
      if (wr_prog && !pll_on_a_q) begin
        mult_q               <= wd[7:4];
        range_select_field_q <= wd[3:0];
      end
      if (wr_bw) begin
        auto_q <= wd[`CKS_BW_AUTO_BIT];
        if (!auto_q) begin
          acq_q <= wd[`CKS_BW_ACQ_BIT];
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Bus slave: one wait cycle, then the answer
  // --------------------------------------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    case (address)
      `CKS_ADDR_PLL_CONTROL: begin
        rd_mux[`CKS_CTL_IRQ_EN_BIT] = lock_irq_enable_q;
        rd_mux[`CKS_CTL_FLAG_BIT]   = lock_change_flag_q & auto_q;
        rd_mux[`CKS_CTL_PLL_ON_BIT] = pll_on_a_q;
        rd_mux[`CKS_CTL_SELECT_BIT] = base_select_q;
        rd_mux[3:0]                 = `CKS_CTL_UNUSED_ONES;
      end
      `CKS_ADDR_PLL_PROGRAM: begin
        rd_mux = {mult_q, range_select_field_q};
      end
      `CKS_ADDR_BANDWIDTH: begin
        rd_mux[`CKS_BW_AUTO_BIT] = auto_q;
        rd_mux[`CKS_BW_LOCK_BIT] = lock_q & auto_q;
        rd_mux[`CKS_BW_ACQ_BIT]  = auto_q ? acq_in : acq_q;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (ce) begin
      if (bus_req && waitrequest) begin
        waitrequest <= 1'b0;
        readdata    <= {24'h00_0000, rd_mux};
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Source edge detectors
  // --------------------------------------------------------------------
  localparam ST_RUN  = 1'b0;
  localparam ST_HOLD = 1'b1;

  reg        state_q;
  reg        active_sel_q;
  reg  [7:0] wait_cnt_q;
  wire [1:0] src_vec = {vco_clock, crystal_clock};
  wire [1:0] rise_w;
  wire [1:0] done_w;
  wire       arm = (state_q == ST_RUN) && (base_select_q != active_sel_q);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_src
      cks_edge_count u_cnt (
        .clk    (clk),
        .rst_n  (rst_sync_q),
        .ce     (ce),
        .arm    (arm),
        .src_in (src_vec[gi]),
        .rise_q (rise_w[gi]),
        .done_q (done_w[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Transition control and divide by two
  // --------------------------------------------------------------------
  // A timeout ends the hold if the old source has stopped, for example
  // when a zero range shuts the loop down while it still drives output.
  wire hold_over = (done_w == 2'b11) || (wait_cnt_q == `CKS_SWITCH_TIMEOUT);

  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q        <= ST_RUN;
      active_sel_q   <= 1'b0;
      wait_cnt_q     <= 8'h00;
      base_clock_out <= 1'b0;
    end else if (ce) begin
      case (state_q)
        ST_RUN: begin
          wait_cnt_q <= 8'h00;
          if (arm) begin
            state_q <= ST_HOLD;
          end else if (rise_w[active_sel_q]) begin
            base_clock_out <= ~base_clock_out & osc_enable_in;
          end
        end
        ST_HOLD: begin
          wait_cnt_q <= wait_cnt_q + 8'h01;
          if (hold_over) begin
            // The new source only toggles the output on its own edge.
            active_sel_q <= base_select_q;
            state_q      <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
      if (!osc_enable_in) begin
        base_clock_out <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Outputs toward the system and the analog loop
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      crystal_clock_out <= 1'b0;
      clock_irq_out     <= 1'b0;
      pll_enable_out    <= 1'b0;
      feedback_mult_out <= 4'h1;
      range_mult_out    <= 4'h0;
      tracking_mode_out <= 1'b0;
    end else if (ce) begin
      crystal_clock_out <= crystal_clock & osc_enable_in;
      clock_irq_out     <= lock_change_flag_q & lock_irq_enable_q & auto_q &
                           osc_enable_in;
      // The oscillator enable from the system unit gates the loop too.
      pll_enable_out    <= pll_on_a_q & ~range_off & osc_enable_in;
      feedback_mult_out <= (mult_q == 4'h0) ? 4'h1 : mult_q;
      range_mult_out    <= range_select_field_q;
      tracking_mode_out <= auto_q ? acq_in : acq_q;
    end
  end

endmodule
`default_nettype wire

/* tb/cks_ctrl_assertions.sv */
// Port-level checks of the base clock select and PLL control block.
`default_nettype none
module cks_ctrl_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Clocks and status
  input wire logic        crystal_clock,
  input wire logic        vco_clock,
  input wire logic        osc_enable_in,
  input wire logic        crystal_clock_out,
  input wire logic        base_clock_out,
  input wire logic        clock_irq_out,
  input wire logic        pll_enable_out,
  input wire logic [3:0]  feedback_mult_out,
  input wire logic [3:0]  range_mult_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Helpers and properties
  // ----------------------------------------------------------------
  logic [2:0] up_q;
  logic       xp_q;
  logic       vp_q;
  logic       rise;
  // The block releases its own reset two edges late, so the crystal follow
  // and base toggle checks wait until that copy has settled.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 3'h0;
      xp_q <= 1'b0;
      vp_q <= 1'b0;
    end else begin
      up_q <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
      xp_q <= crystal_clock;
      vp_q <= vco_clock;
    end
  end
  assign rise = (crystal_clock & ~xp_q) | (vco_clock & ~vp_q);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence taken_s;
    (read || write) && waitrequest;
  endsequence
  sequence answer_s;
    !waitrequest ##1 waitrequest;
  endsequence
  bus_answer_a: assert property (taken_s |=> answer_s)
    else $error("bus answer not a one cycle pulse");
  upper_zero_a: assert property (!waitrequest |-> readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  low_ones_a: assert property (!waitrequest && $past(read) && $past(address) == 8'h1c
    |-> readdata[3:0] == 4'hf) else $error("control low bits not ones");
  stop_low_a: assert property (!osc_enable_in |=>
    !crystal_clock_out && !base_clock_out && !clock_irq_out) else $error("outputs not low");
  xtal_follow_a: assert property (up_q == 3'h7
    |-> crystal_clock_out == $past(crystal_clock && osc_enable_in)) else $error("crystal out");
  range_off_a: assert property (range_mult_out == 4'h0 && $past(range_mult_out) == 4'h0
    |-> !pll_enable_out) else $error("PLL enabled with range zero");
  mult_nonzero_a: assert property (feedback_mult_out != 4'h0)
    else $error("multiplier output zero");
  base_toggle_a: assert property (up_q == 3'h7 && osc_enable_in && $past(osc_enable_in)
    && $past(osc_enable_in, 3) && $changed(base_clock_out)
    |-> $past(rise) || $past(rise, 2) || $past(rise, 3)) else $error("base clock runt");
endmodule
`default_nettype wire

/* tb/cks_siu_model.sv */
// Behavioural model of the system unit and analog side of the block.
`default_nettype none
module cks_siu_model #(
  parameter int XTAL_HALF = 4,
  parameter int VCO_HALF  = 3
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Commands from the bench
  input  wire logic osc_off_cmd,
  input  wire logic stop_cmd,
  input  wire logic lock_cmd,
  // Toward the block
  output var logic  crystal_clock,
  output var logic  vco_clock,
  output var logic  osc_enable_in,
  output var logic  stop_in,
  output var logic  lock_in,
  output var logic  acq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Source clocks and system levels
  // ----------------------------------------------------------------
  int xc;
  int vc;
  // Both sources stay well below clk/2 so the block can sample them.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xc <= 0;
      vc <= 0;
      crystal_clock <= 1'b0;
      vco_clock <= 1'b0;
      osc_enable_in <= 1'b0;
      stop_in <= 1'b0;
      lock_in <= 1'b0;
      acq_in <= 1'b0;
    end else begin
      xc <= (xc == XTAL_HALF - 1) ? 0 : xc + 1;
      vc <= (vc == VCO_HALF - 1) ? 0 : vc + 1;
      if (xc == XTAL_HALF - 1) crystal_clock <= ~crystal_clock;
      if (vc == VCO_HALF - 1) vco_clock <= ~vco_clock;
      osc_enable_in <= ~osc_off_cmd;
      stop_in <= stop_cmd;
      lock_in <= lock_cmd;
      acq_in <= lock_cmd;
    end
  end
endmodule
`default_nettype wire

/* tb/base_clock_select_pll_control_tb.sv */
// Self-checking bench for the base clock select and PLL control block.
`default_nettype none
`include "cks_defines.vh"
module base_clock_select_pll_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Wiring, tasks and tests
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL = `CKS_ADDR_PLL_CONTROL;
  localparam logic [7:0] PRG = `CKS_ADDR_PLL_PROGRAM;
  localparam logic [7:0] BW  = `CKS_ADDR_BANDWIDTH;
  logic        clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata;
  logic        waitrequest, crystal_clock, vco_clock, lock_in, acq_in, osc_enable_in, stop_in;
  logic        crystal_clock_out, base_clock_out, clock_irq_out, pll_enable_out, tracking_mode_out;
  logic [3:0]  feedback_mult_out, range_mult_out;
  logic        osc_off_cmd = 1'b0, stop_cmd = 1'b0, lock_cmd = 1'b0;
  int          errors = 0, tests_run = 0, cycles = 0;
  always #2 clk = ~clk;
  cks_ctrl_top dut (.clk, .rst_n, .ce(1'b1), .address, .read, .write, .writedata,
    .byteenable(4'h1), .readdata, .waitrequest, .crystal_clock, .vco_clock, .lock_in,
    .acq_in, .osc_enable_in, .stop_in, .crystal_clock_out, .base_clock_out, .clock_irq_out,
    .pll_enable_out, .feedback_mult_out, .range_mult_out, .tracking_mode_out);
  cks_siu_model siu (.clk, .rst_n, .osc_off_cmd, .stop_cmd, .lock_cmd, .crystal_clock,
    .vco_clock, .osc_enable_in, .stop_in, .lock_in, .acq_in);
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Holds the request until waitrequest is seen low, then releases and
  // lets one edge pass so the next call never drives in the same step.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    address <= a;
    writedata <= {24'h00_0000, d};
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(name, q, {24'h00_0000, exp});
  endtask
  task automatic lvl(input logic v, inout int n);
    while (base_clock_out !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic per(input string name, input int exp);
    int n;
    n = 0;
    lvl(1'b0, n);
    lvl(1'b1, n);
    n = 0;
    lvl(1'b0, n);
    chk(name, n, exp / 2);
    lvl(1'b1, n);
    chk(name, n, exp);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd("ctl reset", CTL, 8'h2f);
    rd("prg reset", PRG, 8'h66);
    rd("bw reset", BW, 8'h00);
    rd("unmapped", 8'h30, 8'h00);
    per("xtal base", 16);
    wr(PRG, 8'h00);
    rd("prg locked", PRG, 8'h66);
    wr(CTL, 8'h00);
    rd("pll off", CTL, 8'h0f);
    wr(CTL, 8'h30);
    rd("one write", CTL, 8'h2f);
    wr(CTL, 8'h30);
    rd("two writes", CTL, 8'h3f);
    wr(CTL, 8'h10);
    rd("on held", CTL, 8'h3f);
    // Allow for the full switch-over timeout before measuring.
    repeat (80) @(posedge clk);
    per("vco base", 12);
    stop_cmd <= 1'b1;
    @(posedge clk);
    stop_cmd <= 1'b0;
    // The clear lands one edge after the system unit raises its stop level.
    @(posedge clk);
    rd("stop", CTL, 8'h2f);
    wr(CTL, 8'h10);
    rd("select keeps on", CTL, 8'h3f);
    wr(CTL, 8'h20);
    repeat (80) @(posedge clk);
    per("xtal again", 16);
    osc_off_cmd <= 1'b1;
    repeat (20) @(posedge clk);
    chk("osc off", {crystal_clock_out, base_clock_out, clock_irq_out}, 0);
    osc_off_cmd <= 1'b0;
    wr(CTL, 8'h00);
    wr(PRG, 8'h00);
    repeat (2) @(posedge clk);
    chk("mult zero", feedback_mult_out, 1);
    wr(CTL, 8'h20);
    wr(CTL, 8'h30);
    rd("range zero", CTL, 8'h2f);
    chk("pll held off", pll_enable_out, 0);
    wr(CTL, 8'h00);
    wr(PRG, 8'h66);
    wr(BW, 8'h80);
    wr(CTL, 8'ha0);
    lock_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    chk("irq", clock_irq_out, 1);
    rd("flag set", CTL, 8'hef);
    rd("flag cleared", CTL, 8'haf);
    chk("irq off", clock_irq_out, 0);
    rd("lock bit", BW, 8'he0);
    chk("tracking", tracking_mode_out, 1);
    wr(CTL, 8'h20);
    lock_cmd <= 1'b0;
    repeat (6) @(posedge clk);
    chk("masked", clock_irq_out, 0);
    rd("flag masked", CTL, 8'h6f);
    wr(BW, 8'h00);
    wr(CTL, 8'ha0);
    lock_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    rd("manual ctl", CTL, 8'h2f);
    rd("manual bw", BW, 8'h00);
    end_sim();
  end
endmodule
bind cks_ctrl_top cks_ctrl_checker u_chk (.clk, .rst_n, .address, .read, .write, .readdata,
  .waitrequest, .crystal_clock, .vco_clock, .osc_enable_in, .crystal_clock_out,
  .base_clock_out, .clock_irq_out, .pll_enable_out, .feedback_mult_out, .range_mult_out);
`default_nettype wire
